// File: core/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
  // Control port map and reset value
  localparam logic [7:0] MODE_ADDR = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h01;
  // Device addresses, values arbitrary
  localparam logic [4:0] I2C_BASE = 5'h09;
  localparam logic [6:0] SPI_DEV = 7'h4C;
  // Mute ramp lengths in frame clock cycles
  localparam logic [12:0] RAMP_SINGLE = 13'h0480;
  localparam logic [12:0] RAMP_DOUBLE = 13'h0900;
  localparam logic [12:0] RAMP_QUAD = 13'h1200;
  // Offset calibration run time in ref_clk cycles
  localparam logic [9:0] CAL_CYCLES = 10'h0200;
  // SPI frame length: chip byte, map byte, data byte
  localparam logic [4:0] SPI_LAST = 5'h17;
  localparam logic [4:0] SPI_STOP = 5'h18;

  // Mode control register layout, bit 7 first
  typedef struct packed {
    logic trimGo;
    logic quietN;
    logic [4:0] fmt;
    logic sleep;
  } mode_t;

  typedef struct packed {
    logic analogDown;
    logic digitalDown;
  } power_t;

  typedef enum logic [1:0] {SPEED_SINGLE, SPEED_DOUBLE, SPEED_QUAD} speed_t;
  typedef enum {I_IDLE, I_ADDR, I_MAP, I_DATA, I_READ} i2c_state_t;

  // Clocking mode from the format field
  function automatic speed_t speed_of(logic [4:0] fmt);
    speed_of = fmt[4] ? SPEED_QUAD : (fmt[3] ? SPEED_DOUBLE : SPEED_SINGLE);
  endfunction : speed_of

  // Ramp length for a clocking mode
  function automatic logic [12:0] ramp_len(speed_t s);
    case (s)
      SPEED_QUAD: ramp_len = RAMP_QUAD;
      SPEED_DOUBLE: ramp_len = RAMP_DOUBLE;
      default: ramp_len = RAMP_SINGLE;
    endcase
  endfunction : ramp_len
endpackage : dac_ctrl_pkg

// File: core/dac_mode_control_soft_mute.sv
`timescale 1ns/1ps
// Function
// [RULE_01] Mode register at 0x01, fixed bit layout
// [RULE_02] Calibration bit self-clears when done
// [RULE_03] Mute ramp length follows speed mode
// [RULE_04] Indicator low only after full ramp
// [RULE_05] Unmute ramp uses same length
// [RULE_06] Indicator rises at once on unmute
// [RULE_07] Sleep bit powers down both sections
// [RULE_08] Sleep resets to one; host clears it
// [RULE_09] Format field resets to zero
// [RULE_10] Format field selects de-emphasis
// [RULE_11] Format field selects clocking speed
// [RULE_12] Reset clears all state, low power; code leaves the pin synchronisers and the SPI shifter out of reset
// [RULE_13] Host waits 500 ns before I2C start
// [RULE_14] Host waits 500 ns before first CS fall
// [RULE_15] CS fall switches port to SPI, sticky; code returns to I2C when the sleep bit is set
module dac_mode_control_soft_mute
  import dac_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control port pins
  input wire logic control_clock,
  input wire logic chipSelect,
  input wire logic control_data_in,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  // Audio frame clock
  input wire logic channel_frame_clock,
  // Converter controls
  output logic silence_indicator_n,
  output power_t power,
  output logic [4:0] formatSelect,
  output speed_t speedMode,
  output logic deemphOn,
  output logic trimActive,
  output logic [12:0] rampLevel,
  output logic spiMode
);

  mode_t mode;
  logic [9:0] calCnt;
  logic [12:0] len;
  logic wrHit;
  logic [7:0] wrByte;
  // Pin synchronisers
  logic sclM, sclS, sclP;
  logic sdaM, sdaS, sdaP;
  logic csM, csS, csP;
  logic ad1M, ad1S;
  logic frM, frS, frP;
  logic frameEdge;
  // I2C engine
  i2c_state_t iState;
  logic [3:0] bitCnt;
  logic ackPh;
  logic [7:0] rxByte, txByte;
  logic i2cWr;
  logic [7:0] i2cMap, i2cData;
  logic start, stop, sclRise, sclFall;
  // SPI link side
  logic [22:0] spiShift;
  logic [4:0] spiCnt;
  logic [23:0] spiFrame;
  logic [15:0] spiWord;
  logic spiTog;
  logic togM, togS, togP;
  logic spiEvent;
  logic sleepP;
  // Two-flop synchronisers for pins and the SPI toggle
  always_ff @(posedge ref_clk)
  begin
    sclM <= control_clock;
    sclS <= sclM;
    sdaM <= serialDataIn;
    sdaS <= sdaM;
    csM <= chipSelect;
    csS <= csM;
    ad1M <= control_data_in;
    ad1S <= ad1M;
    frM <= channel_frame_clock;
    frS <= frM;
    togM <= spiTog;
    togS <= togM;
  end
  // Previous values for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sclP <= 1'b1;
      sdaP <= 1'b1;
      csP <= 1'b1;
      frP <= 1'b0;
      togP <= 1'b0;
      sleepP <= 1'b1;
    end
    else
    begin
      sclP <= sclS;
      sdaP <= sdaS;
      csP <= csS;
      frP <= frS;
      togP <= togS;
      sleepP <= mode.sleep;
    end
  end
  // Bus events
  assign start = sclS && sclP && sdaP && !sdaS;
  assign stop = sclS && sclP && !sdaP && sdaS;
  assign sclRise = sclS && !sclP;
  assign sclFall = !sclS && sclP;
  assign frameEdge = frS && !frP;
  assign spiEvent = togS ^ togP;
  // SPI shifter, cleared while chip select is high
  always_ff @(posedge control_clock or posedge chipSelect)
  begin
    if (chipSelect)
    begin
      spiShift <= '0;
      spiCnt <= '0;
    end
    else if (spiCnt != SPI_STOP)
    begin
      spiShift <= {spiShift[21:0], control_data_in};
      spiCnt <= spiCnt + 5'd1;
    end
  end
  assign spiFrame = {spiShift, control_data_in};
  // Completed SPI write handed over by toggle
  always_ff @(posedge control_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spiWord <= '0;
      spiTog <= 1'b0;
    end
    else if (spiCnt == SPI_LAST && spiFrame[23:17] == SPI_DEV && !spiFrame[16])
    begin
      spiWord <= spiFrame[15:0];
      spiTog <= ~spiTog;
    end
  end
  // Port mode: SPI after any chip select fall
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      spiMode <= 1'b0;
    else if (csP && !csS)
      spiMode <= 1'b1; // [RULE_15]
    else if (mode.sleep && !sleepP)
      spiMode <= 1'b0; // [RULE_15]
  end
  // I2C slave on oversampled pins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || spiMode)
    begin
      iState <= I_IDLE;
      bitCnt <= '0;
      ackPh <= 1'b0;
      rxByte <= '0;
      txByte <= '0;
      serialDataOe <= 1'b0;
      i2cWr <= 1'b0;
      i2cMap <= '0;
      i2cData <= '0;
    end
    else
    begin
      i2cWr <= 1'b0;
      if (start)
      begin
        iState <= I_ADDR;
        bitCnt <= '0;
        ackPh <= 1'b0;
        serialDataOe <= 1'b0;
      end
      else if (stop)
      begin
        iState <= I_IDLE;
        serialDataOe <= 1'b0;
      end
      else if (iState != I_IDLE)
      begin
        if (sclRise && !ackPh)
        begin
          rxByte <= {rxByte[6:0], sdaS};
          bitCnt <= bitCnt + 4'd1;
        end
        if (sclRise && ackPh && iState == I_READ && sdaS)
          iState <= I_IDLE;
        if (sclFall)
        begin
          if (ackPh)
          begin
            ackPh <= 1'b0;
            bitCnt <= '0;
            serialDataOe <= (iState == I_READ) && !txByte[7];
          end
          else if (bitCnt == 4'd8)
          begin
            ackPh <= 1'b1;
            case (iState)
              I_ADDR:
                if (rxByte[7:1] == {I2C_BASE, ad1S, csS})
                begin
                  serialDataOe <= 1'b1;
                  iState <= rxByte[0] ? I_READ : I_MAP;
                  txByte <= mode;
                end
                else
                  iState <= I_IDLE;
              I_MAP:
              begin
                i2cMap <= rxByte;
                serialDataOe <= 1'b1;
                iState <= I_DATA;
              end
              I_DATA:
              begin
                i2cData <= rxByte;
                i2cWr <= 1'b1;
                serialDataOe <= 1'b1;
              end
              I_READ:
              begin
                serialDataOe <= 1'b0;
                txByte <= mode;
              end
              default: iState <= I_IDLE;
            endcase
          end
          else if (iState == I_READ && bitCnt != 4'd0)
          begin
            serialDataOe <= !txByte[6];
            txByte <= {txByte[6:0], 1'b0};
          end
        end
      end
    end
  end
  // Register write strobe from the active port
  always_comb
  begin
    wrHit = (i2cWr && i2cMap == MODE_ADDR) ||
      (spiEvent && spiMode && spiWord[15:8] == MODE_ADDR); // [RULE_01]
    wrByte = i2cWr ? i2cData : spiWord[7:0];
  end
  // Mode control register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      mode <= mode_t'(MODE_RESET); // [RULE_08] [RULE_09] [RULE_12]
    else if (wrHit)
      mode <= mode_t'(wrByte); // [RULE_01]
    else if (mode.trimGo && calCnt == 10'd1)
      mode.trimGo <= 1'b0; // [RULE_02]
  end
  // Calibration run counter
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      calCnt <= '0;
    else if (wrHit)
      calCnt <= wrByte[7] ? CAL_CYCLES : 10'd0; // [RULE_02]
    else if (calCnt != 10'd0)
      calCnt <= calCnt - 10'd1;
  end
  assign len = ramp_len(speed_of(mode.fmt)); // [RULE_11]
  // Soft mute ramp level, one step per frame
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rampLevel <= '0;
    else if (rampLevel > len)
      rampLevel <= len;
    else if (frameEdge)
    begin
      if (!mode.quietN && rampLevel != 13'd0)
        rampLevel <= rampLevel - 13'd1; // [RULE_03]
      else if (mode.quietN && rampLevel != len)
        rampLevel <= rampLevel + 13'd1; // [RULE_05]
    end
  end
  // Mute indicator
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      silence_indicator_n <= 1'b0;
    else
      silence_indicator_n <= mode.quietN || rampLevel != 13'd0; // [RULE_04] [RULE_06]
  end
  // Converter control outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      power <= '{1'b1, 1'b1}; // [RULE_12]
      formatSelect <= '0;
      speedMode <= SPEED_SINGLE;
      deemphOn <= 1'b0;
      trimActive <= 1'b0;
      serialDataOut <= 1'b0;
    end
    else
    begin
      power <= '{mode.sleep, mode.sleep}; // [RULE_07]
      formatSelect <= mode.fmt; // [RULE_09]
      speedMode <= speed_of(mode.fmt); // [RULE_11]
      deemphOn <= speed_of(mode.fmt) == SPEED_SINGLE && mode.fmt[2]; // [RULE_10]
      trimActive <= mode.trimGo;
      serialDataOut <= 1'b0;
    end
  end
  // Checks
  localparam int CAL_MAX = 520;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_reset_val;
    $rose(rst_b) |-> mode == mode_t'(MODE_RESET) && !spiMode;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value"); // [RULE_08]
  property p_cal_done;
    $rose(mode.trimGo) ##1 !wrHit[*8] |-> ##[1:CAL_MAX] !mode.trimGo;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("cal never ends"); // [RULE_02]
  property p_ramp_down;
    frameEdge && !mode.quietN && !wrHit && rampLevel != 13'd0 && rampLevel <= len
      |=> rampLevel == $past(rampLevel) - 13'd1;
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("no ramp down"); // [RULE_03]
  property p_ramp_up;
    frameEdge && mode.quietN && !wrHit && rampLevel < len
      |=> rampLevel == $past(rampLevel) + 13'd1;
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("no ramp up"); // [RULE_05]
  property p_ind_low;
    !silence_indicator_n |-> $past(rampLevel) == 13'd0 && !$past(mode.quietN);
  endproperty
  a_ind_low: assert property (p_ind_low) else $error("early mute flag"); // [RULE_04]
  property p_ind_high;
    $rose(mode.quietN) |=> silence_indicator_n;
  endproperty
  a_ind_high: assert property (p_ind_high) else $error("late unmute flag"); // [RULE_06]
  property p_sleep;
    mode.sleep |=> power.analogDown && power.digitalDown;
  endproperty
  a_sleep: assert property (p_sleep) else $error("not powered down"); // [RULE_07]
  property p_spi_sticky;
    spiMode && !(mode.sleep && !sleepP) |=> spiMode;
  endproperty
  a_spi_sticky: assert property (p_spi_sticky) else $error("left spi mode"); // [RULE_15]
  // The written field must reach the format output, and the speed must follow it
  property p_speed;
    wrHit ##1 !wrHit |=> formatSelect == $past(wrByte[5:1], 2) &&
      speedMode == speed_of(formatSelect);
  endproperty
  a_speed: assert property (p_speed) else $error("wrong speed"); // [RULE_11]
  c_full_mute: cover property (!mode.quietN ##1 !silence_indicator_n);
  c_unmute: cover property ($rose(silence_indicator_n));
  c_cal: cover property ($fell(mode.trimGo));
  c_spi_wr: cover property (wrHit && spiMode);
endmodule : dac_mode_control_soft_mute

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import dac_ctrl_pkg::*;
(
  // Control port pins toward the device
  output logic control_clock,
  output logic chipSelect,
  output logic control_data_in,
  output logic serialDataIn,
  // Device side of the open-drain data line
  input wire logic serialDataOut,
  input wire logic serialDataOe
);
  localparam int H = 300;
  logic sdaLow;

  // Open-drain data line with a pull-up
  assign serialDataIn = !(sdaLow || (serialDataOe && !serialDataOut));

  // Bus idle, clock high in the two-wire mode
  initial
  begin
    control_clock = 1'h1;
    chipSelect = 1'h1;
    control_data_in = 1'h0;
    sdaLow = 1'h0;
  end

  // Start: data falls while the clock is high
  task automatic startCond();
    control_clock = 1'h1;
    sdaLow = 1'h0;
    #H sdaLow = 1'h1;
    #H control_clock = 1'h0;
  endtask : startCond

  // Stop: data rises while the clock is high
  task automatic stopCond();
    sdaLow = 1'h1;
    #H control_clock = 1'h1;
    #H sdaLow = 1'h0;
    #H;
  endtask : stopCond

  // Eight bits plus the acknowledge clock; samples the wire late in each high phase
  task automatic i2cByte(input logic [7:0] b, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaLow = !b[i];
      #H control_clock = 1'h1;
      #H r[i] = serialDataIn;
      control_clock = 1'h0;
    end
    sdaLow = 1'h0;
    #H control_clock = 1'h1;
    #H ack = !serialDataIn;
    control_clock = 1'h0;
  endtask : i2cByte

  // Address, map byte, data byte; ok is set when all three were acknowledged
  task automatic i2cWrite(input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    startCond();
    i2cByte({I2C_BASE, control_data_in, chipSelect, 1'h0}, r, a0);
    i2cByte(MODE_ADDR, r, a1);
    i2cByte(data, r, a2);
    stopCond();
    ok = a0 & a1 & a2;
  endtask : i2cWrite

  // Address with read bit, one data byte, then not-acknowledge
  task automatic i2cRead(output logic [7:0] data);
    logic a;
    startCond();
    i2cByte({I2C_BASE, control_data_in, chipSelect, 1'h1}, data, a);
    i2cByte(8'hFF, data, a);
    stopCond();
  endtask : i2cRead

  // Serial frame; the clock stands low outside it
  task automatic spiWrite(input logic [7:0] chip, input logic [7:0] data);
    logic [23:0] f;
    f = {chip, MODE_ADDR, data};
    control_clock = 1'h0;
    #500 chipSelect = 1'h0;
    for (int i = 23; i >= 0; i--)
    begin
      control_data_in = f[i];
      #6 control_clock = 1'h1;
      #6 control_clock = 1'h0;
    end
    #6 chipSelect = 1'h1;
    control_data_in = !control_data_in;
  endtask : spiWrite
endmodule : host_model

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import dac_ctrl_pkg::*;
  logic ref_clk, rst_b, ok;
  logic [1:0] fdiv;
  logic control_clock, chipSelect, control_data_in, serialDataIn;
  logic serialDataOut, serialDataOe, silence_indicator_n, deemphOn, trimActive, spiMode;
  power_t power;
  logic [4:0] formatSelect;
  speed_t speedMode;
  logic [12:0] rampLevel;
  logic [7:0] rd;
  int n, cyc, nErrors, checkCount;
  localparam logic [7:0] DEV = {SPI_DEV, 1'h0};

  dac_mode_control_soft_mute dut (.ref_clk, .rst_b, .control_clock, .chipSelect,
    .control_data_in, .serialDataIn, .serialDataOut, .serialDataOe,
    .channel_frame_clock(fdiv[1]), .silence_indicator_n, .power, .formatSelect,
    .speedMode, .deemphOn, .trimActive, .rampLevel, .spiMode);
  host_model host (.control_clock, .chipSelect, .control_data_in, .serialDataIn,
    .serialDataOut, .serialDataOe);

  // Clock and frame clock, one frame edge every four cycles
  initial
  begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) fdiv <= fdiv + 2'h1;

  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      nErrors++;
      endOfTest();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // All outputs except serialDataOut at their reset state
  task automatic chkReset();
    chk({serialDataOe, silence_indicator_n, power, formatSelect, speedMode, deemphOn,
      trimActive, rampLevel, spiMode}, {2'h0, 2'h3, 9'h000, 13'h0000, 1'h0}, "reset");
  endtask : chkReset

  // Bounded wait for a ramp level
  task automatic waitLevel(input logic [12:0] v);
    for (int i = 0; i < 20000 && rampLevel !== v; i++)
      @(posedge ref_clk);
    chk(rampLevel, v, "ramp level");
  endtask : waitLevel

  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endOfTest

  // Main sequence
  initial
  begin
    rst_b = 1'h0;
    fdiv = 2'h0;
    repeat (4) @(posedge ref_clk);
    chkReset();
    rst_b <= 1'h1;
    repeat (10) @(posedge ref_clk);
    host.i2cRead(rd);
    chk(rd, MODE_RESET, "read reset");
    host.i2cWrite(8'h48, ok);
    chk(ok, 1'h1, "acks");
    repeat (6) @(posedge ref_clk);
    chk(silence_indicator_n, 1'h1, "unmute flag");
    chk(power, 2'h0, "awake");
    chk({formatSelect, deemphOn, speedMode}, {5'h04, 1'h1, SPEED_SINGLE}, "fmt");
    waitLevel(RAMP_SINGLE);
    host.i2cWrite(8'hC8, ok);
    host.i2cRead(rd);
    chk({rd, trimActive}, {8'hC8, 1'h1}, "trim run");
    repeat (600) @(posedge ref_clk);
    host.i2cRead(rd);
    chk({rd, trimActive}, {8'h48, 1'h0}, "trim done");
    host.spiWrite(8'h00, 8'h60);
    repeat (8) @(posedge ref_clk);
    chk({spiMode, formatSelect}, {1'h1, 5'h04}, "bad chip");
    host.spiWrite(DEV, 8'h50);
    repeat (8) @(posedge ref_clk);
    chk({speedMode, deemphOn}, {SPEED_DOUBLE, 1'h0}, "double");
    waitLevel(RAMP_DOUBLE);
    host.spiWrite(DEV, 8'h60);
    repeat (8) @(posedge ref_clk);
    chk({speedMode, deemphOn}, {SPEED_QUAD, 1'h0}, "quad");
    waitLevel(RAMP_QUAD);
    host.spiWrite(DEV, 8'h20);
    n = 0;
    while (silence_indicator_n !== 1'h0 && n < 25000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= 4 * RAMP_QUAD - 16 && n <= 4 * RAMP_QUAD + 16, 1'h1, "mute len");
    chk(rampLevel, 13'h0000, "muted");
    host.spiWrite(DEV, 8'h60);
    repeat (8) @(posedge ref_clk);
    chk(silence_indicator_n, 1'h1, "unmute");
    host.spiWrite(DEV, 8'h61);
    repeat (8) @(posedge ref_clk);
    chk({power, spiMode}, {2'h3, 1'h0}, "sleep");
    rst_b <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chkReset();
    endOfTest();
  end
endmodule : tb
